// ---- utc_timer.sv ----
// 16-bit up/down timer with capture and auto-reload, APB register slave
`timescale 1ns/1ns
module utc_timer
    import utc_pkg::*;
(
    input  wire logic        clk_sys,    // System clock, 10 MHz
    input  wire logic        srst,       // Synchronous reset, active high
    input  wire logic        ce,         // Clock enable, freezes all state
    input  wire logic        psel,       // APB select
    input  wire logic        penable,    // APB enable
    input  wire logic        pwrite,     // APB write
    input  wire logic [7:0]  paddr,      // APB byte address
    input  wire logic [31:0] pwdata,     // APB write data
    output logic      [31:0] prdata,     // APB read data
    output logic             pready,     // APB ready
    output logic             pslverr,    // APB error on unmapped address
    input  wire logic        extTrigPin, // External trigger / direction pin
    input  wire logic        extCountPin,// External count pin
    input  wire logic        extOscClk,  // External oscillator clock
    output logic             irq         // Level interrupt
);

    ////////////////////////////////////////////////////////////////////////
    // Address decode

    function automatic logic isMapped(input logic [7:0] a);
        isMapped = (a == OFS_CTRL) || (a == OFS_CFG) || (a == OFS_CNT_LO) ||
                   (a == OFS_CNT_HI) || (a == OFS_RC_LO) || (a == OFS_RC_HI) ||
                   (a == OFS_STAT) || (a == OFS_MASK);
    endfunction

    logic        wrAcc;
    logic        wrCtrl;
    logic        wrCfg;
    logic        wrCntLo;
    logic        wrCntHi;
    logic        wrRcLo;
    logic        wrRcHi;
    logic        wrStat;
    logic        wrMask;

    // Zero-wait slave: an access phase completes in one cycle whenever ce is high
    assign pready  = ce;
    assign pslverr = ce & psel & penable & ~isMapped(paddr);
    assign wrAcc   = ce & psel & penable & pwrite;
    assign wrCtrl  = wrAcc & (paddr == OFS_CTRL);
    assign wrCfg   = wrAcc & (paddr == OFS_CFG);
    assign wrCntLo = wrAcc & (paddr == OFS_CNT_LO);
    assign wrCntHi = wrAcc & (paddr == OFS_CNT_HI);
    assign wrRcLo  = wrAcc & (paddr == OFS_RC_LO);
    assign wrRcHi  = wrAcc & (paddr == OFS_RC_HI);
    assign wrStat  = wrAcc & (paddr == OFS_STAT);
    assign wrMask  = wrAcc & (paddr == OFS_MASK);

    ////////////////////////////////////////////////////////////////////////
    // Control and configuration state

    logic        wrapFlag;
    logic        extFlag;
    logic        extEn;
    logic        runBit;
    logic        counterSel;
    logic        capRelSel;
    utc_clksel_t clkSel;
    logic        downEn;
    logic [1:0]  irqMask;
    logic [15:0] cnt;
    logic [15:0] rcap;

    // Mode bits are plain read/write
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            extEn      <= 1'b0;
            runBit     <= 1'b0;
            counterSel <= 1'b0;
            capRelSel  <= 1'b0;
        end else if (ce && wrCtrl) begin
            extEn      <= pwdata[CTL_EXTEN];
            runBit     <= pwdata[CTL_RUN];
            counterSel <= pwdata[CTL_CSEL];
            capRelSel  <= pwdata[CTL_CPRL];
        end
    end

    // Clock select and down-count enable
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            clkSel <= CLK_SYS1;
            downEn <= 1'b0;
        end else if (ce && wrCfg) begin
            clkSel <= utc_clksel_t'(pwdata[CFG_CLK_LO +: 2]);
            downEn <= pwdata[CFG_DOWN];
        end
    end

    // Interrupt mask
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            irqMask <= RST_MASK;
        end else if (ce && wrMask) begin
            irqMask <= pwdata[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin inputs, each through two flip-flops

    logic trigLevel;
    logic trigFall;
    logic cntFall;
    logic oscRise;

    utc_pin_sync uTrig (
        .clk_sys (clk_sys),
        .srst    (srst),
        .ce      (ce),
        .pinIn   (extTrigPin),
        .level   (trigLevel),
        .fall    (trigFall),
        .rise    ()
    );

    utc_pin_sync uCount (
        .clk_sys (clk_sys),
        .srst    (srst),
        .ce      (ce),
        .pinIn   (extCountPin),
        .level   (),
        .fall    (cntFall),
        .rise    ()
    );

    utc_pin_sync uOsc (
        .clk_sys (clk_sys),
        .srst    (srst),
        .ce      (ce),
        .pinIn   (extOscClk),
        .level   (),
        .fall    (),
        .rise    (oscRise)
    );

    ////////////////////////////////////////////////////////////////////////
    // Prescalers and count tick

    logic [3:0] preCnt;
    logic [2:0] oscCnt;
    logic       intTick;
    logic       tick;

    // Free-running divide-by-12 chain; bit 0 doubles as divide-by-2
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            preCnt <= 4'h0;
        end else if (ce) begin
            preCnt <= (preCnt == PRE_LAST) ? 4'h0 : preCnt + 4'h1;
        end
    end

    // Oscillator edges divided by 8; oscillator must be well below clk_sys/2
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            oscCnt <= 3'h0;
        end else if (ce && oscRise) begin
            oscCnt <= oscCnt + 3'h1;
        end
    end

    // Select the count event source
    always_comb begin
        unique case (clkSel)
            CLK_SYS1:  intTick = 1'b1;
            CLK_SYS2:  intTick = preCnt[0];
            CLK_SYS12: intTick = (preCnt == PRE_LAST);
            CLK_OSC8:  intTick = oscRise & (oscCnt == OSC_LAST);
        endcase
        tick = counterSel ? cntFall : intTick;
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter core

    logic        countUp;
    logic        trigEvt;
    logic        adv;
    logic        capEv;
    logic        rldTrig;
    logic        wrapEv;
    logic [15:0] next_cnt;

    assign countUp = downEn ? trigLevel : 1'b1;
    assign trigEvt = trigFall & extEn & ~downEn;
    assign adv     = runBit & tick;
    assign capEv   = capRelSel & trigEvt;
    assign rldTrig = ~capRelSel & trigEvt;

    // Next count; a trigger reload takes priority over a count tick
    always_comb begin
        next_cnt = cnt;
        wrapEv   = 1'b0;
        if (rldTrig) begin
            next_cnt = rcap;
        end else if (adv) begin
            if (capRelSel) begin
                if (countUp) begin
                    next_cnt = cnt + 16'h0001;
                    wrapEv   = (cnt == CNT_MAX);
                end else begin
                    next_cnt = cnt - 16'h0001;
                    wrapEv   = (cnt == CNT_ZERO);
                end
            end else if (countUp) begin
                if (cnt == CNT_MAX) begin
                    next_cnt = rcap;
                    wrapEv   = 1'b1;
                end else begin
                    next_cnt = cnt + 16'h0001;
                end
            end else begin
                if (cnt == rcap) begin
                    next_cnt = CNT_MAX;
                    wrapEv   = 1'b1;
                end else begin
                    next_cnt = cnt - 16'h0001;
                end
            end
        end
    end

    // Count register; a software byte write beats hardware in that cycle
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cnt <= RST_CNT;
        end else if (ce) begin
            cnt <= next_cnt;
            if (wrCntLo) begin
                cnt[7:0] <= pwdata[7:0];
            end
            if (wrCntHi) begin
                cnt[15:8] <= pwdata[7:0];
            end
        end
    end

    // Reload/capture pair; capture beats a software write
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rcap <= RST_RC;
        end else if (ce) begin
            if (capEv) begin
                rcap <= cnt;
            end else begin
                if (wrRcLo) begin
                    rcap[7:0] <= pwdata[7:0];
                end
                if (wrRcHi) begin
                    rcap[15:8] <= pwdata[7:0];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky flags and interrupt

    logic wrapClr;
    logic extClr;
    logic extSet;
    logic extTgl;

    // Clear by writing 0 in control or 1 in status
    assign wrapClr = (wrCtrl & ~pwdata[CTL_WRAP]) | (wrStat & pwdata[ST_WRAP]);
    assign extClr  = (wrCtrl & ~pwdata[CTL_EXT]) | (wrStat & pwdata[ST_EXT]);
    assign extSet  = trigEvt;
    assign extTgl  = ~capRelSel & wrapEv;

    // Hardware set wins over a clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wrapFlag <= 1'b0;
        end else if (ce) begin
            if (wrapEv) begin
                wrapFlag <= 1'b1;
            end else if (wrapClr) begin
                wrapFlag <= 1'b0;
            end
        end
    end

    // External flag: set by any trigger event (capture or reload), or toggled as seventeenth count bit in reload mode
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            extFlag <= 1'b0;
        end else if (ce) begin
            if (extSet) begin
                extFlag <= 1'b1;
            end else if (extTgl) begin
                extFlag <= ~extFlag;
            end else if (extClr) begin
                extFlag <= 1'b0;
            end
        end
    end

    // Registered interrupt; external flag requests only in capture mode
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= (wrapFlag & irqMask[ST_WRAP]) |
                   (extFlag & capRelSel & irqMask[ST_EXT]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, captured in the setup phase

    logic [31:0] rdData;

    always_comb begin
        rdData = 32'h0000_0000;
        unique case (1'b1)
            paddr == OFS_CTRL: begin
                rdData[CTL_WRAP]  = wrapFlag;
                rdData[CTL_EXT]   = extFlag;
                rdData[CTL_EXTEN] = extEn;
                rdData[CTL_RUN]   = runBit;
                rdData[CTL_CSEL]  = counterSel;
                rdData[CTL_CPRL]  = capRelSel;
            end
            paddr == OFS_CFG: begin
                rdData[CFG_CLK_LO +: 2] = clkSel;
                rdData[CFG_DOWN]        = downEn;
            end
            paddr == OFS_CNT_LO: rdData[7:0] = cnt[7:0];
            paddr == OFS_CNT_HI: rdData[7:0] = cnt[15:8];
            paddr == OFS_RC_LO:  rdData[7:0] = rcap[7:0];
            paddr == OFS_RC_HI:  rdData[7:0] = rcap[15:8];
            paddr == OFS_STAT: begin
                rdData[ST_WRAP] = wrapFlag;
                rdData[ST_EXT]  = extFlag;
            end
            paddr == OFS_MASK:   rdData[1:0] = irqMask;
            default:             rdData = 32'h0000_0000;
        endcase
    end

    // Sampled one cycle before the access phase, so it cannot glitch
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            prdata <= 32'h0000_0000;
        end else if (ce && psel && !penable) begin
            prdata <= rdData;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    logic noCntWr;
    assign noCntWr = ~wrCntLo & ~wrCntHi;

    AST_CAP_UP_WRAP: assert property (
        ce && adv && capRelSel && countUp && !rldTrig && cnt == CNT_MAX && noCntWr
        |=> cnt == CNT_ZERO && wrapFlag)
        else $error("capture mode overflow did not wrap or flag");

    AST_CAP_DN_WRAP: assert property (
        ce && adv && capRelSel && !countUp && !rldTrig && cnt == CNT_ZERO && noCntWr
        |=> cnt == CNT_MAX && wrapFlag)
        else $error("capture mode underflow did not wrap or flag");

    AST_CAPTURE: assert property (
        ce && capEv |=> rcap == $past(cnt) && extFlag)
        else $error("capture did not copy count or set flag");

    AST_TRIG_IGNORED: assert property (
        ce && trigFall && (!extEn || downEn) && !wrRcLo && !wrRcHi
        |=> $stable(rcap))
        else $error("ignored trigger changed reload pair");

    AST_RUN_HOLD: assert property (
        ce && !runBit && !rldTrig && noCntWr |=> $stable(cnt) && !$rose(wrapFlag))
        else $error("count moved while stopped");

    AST_RLD_UP: assert property (
        ce && adv && !capRelSel && countUp && !rldTrig && cnt == CNT_MAX && noCntWr
        |=> cnt == $past(rcap) && wrapFlag && extFlag != $past(extFlag))
        else $error("reload overflow wrong");

    AST_RLD_DN: assert property (
        ce && adv && !capRelSel && !countUp && !rldTrig && cnt == rcap && noCntWr
        |=> cnt == CNT_MAX && wrapFlag)
        else $error("reload underflow wrong");

    AST_TRIG_RELOAD: assert property (
        ce && rldTrig && noCntWr |=> cnt == $past(rcap))
        else $error("trigger reload missing");

    AST_FLAG_STICKY: assert property (
        ce && wrapFlag && !wrapClr |=> wrapFlag)
        else $error("wrap flag dropped without software clear");

    AST_DIV2: assert property (
        ce && clkSel == CLK_SYS2 && !counterSel && tick ##1 ce |-> !tick)
        else $error("divide by two ticked twice in a row");

    AST_NO_EXT_IRQ: assert property (
        ce && !capRelSel && !wrapFlag |=> !irq)
        else $error("reload mode external flag raised interrupt");

    CV_CAPTURE:    cover property (ce && capEv);
    CV_RLD_UNDER:  cover property (ce && adv && !capRelSel && !countUp && wrapEv);
    CV_RLD_OVER:   cover property (ce && adv && !capRelSel && countUp && wrapEv);
    CV_IRQ:        cover property ($rose(irq));

endmodule // utc_timer

// ---- utc_pkg.sv ----
// Shared constants and types for the up/down timer with capture and reload
package utc_pkg;

    // Register byte offsets on the APB bus
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_CFG    = 8'h04;
    localparam logic [7:0] OFS_CNT_LO = 8'h08;
    localparam logic [7:0] OFS_CNT_HI = 8'h0c;
    localparam logic [7:0] OFS_RC_LO  = 8'h10;
    localparam logic [7:0] OFS_RC_HI  = 8'h14;
    localparam logic [7:0] OFS_STAT   = 8'h18;
    localparam logic [7:0] OFS_MASK   = 8'h1c;

    // Control register fields
    localparam int CTL_WRAP  = 7;
    localparam int CTL_EXT   = 6;
    localparam int CTL_EXTEN = 3;
    localparam int CTL_RUN   = 2;
    localparam int CTL_CSEL  = 1;
    localparam int CTL_CPRL  = 0;

    // Configuration register fields
    localparam int CFG_CLK_LO = 3;
    localparam int CFG_DOWN   = 0;

    // Status and mask fields share one layout
    localparam int ST_WRAP = 0;
    localparam int ST_EXT  = 1;

    // Values after reset
    localparam logic [15:0] RST_CNT  = 16'h0000;
    localparam logic [15:0] RST_RC   = 16'h0000;
    localparam logic [1:0]  RST_MASK = 2'h0;

    // Count limits
    localparam logic [15:0] CNT_MAX  = 16'hffff;
    localparam logic [15:0] CNT_ZERO = 16'h0000;

    // Prescaler terminal counts: divide by 12 and by 8
    localparam logic [3:0] PRE_LAST = 4'hb;
    localparam logic [2:0] OSC_LAST = 3'h7;

    // Timer clock source selection
    typedef enum logic [1:0] {
        CLK_SYS1  = 2'h0,
        CLK_SYS2  = 2'h1,
        CLK_SYS12 = 2'h2,
        CLK_OSC8  = 2'h3
    } utc_clksel_t;

endpackage

// ---- utc_pin_sync.sv ----
// Two-stage pin synchroniser with edge detection
`timescale 1ns/1ns
module utc_pin_sync (
    input  wire logic clk_sys, // System clock
    input  wire logic srst,    // Synchronous reset, active high
    input  wire logic ce,      // Clock enable
    input  wire logic pinIn,   // Asynchronous pin
    output logic      level,   // Synchronised level
    output logic      fall,    // High-to-low pulse
    output logic      rise     // Low-to-high pulse
);
    logic meta;
    logic sync;
    logic prev;

    // Outputs read only the second stage and its delayed copy, never the first stage
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
        end else if (ce) begin
            meta <= pinIn;
            sync <= meta;
            prev <= sync;
        end
    end

    assign level = sync;
    assign fall  = prev & ~sync;
    assign rise  = ~prev & sync;
endmodule // utc_pin_sync

// ---- utc_pin_model.sv ----
// Model of the timer's external pins: count input, trigger/direction input, oscillator
`timescale 1ns/1ns
module utc_pin_model (
    input  wire logic clk_sys, // System clock, paces pin changes
    output logic      cntPin,  // Count pin, idles high
    output logic      trigPin, // Trigger or direction pin
    output logic      oscClk   // External oscillator
);
    // Pins idle high; oscillator free-running, well under half the system rate
    initial begin
        cntPin = 1'b1;
        trigPin = 1'b1;
        oscClk = 1'b0;
        forever #170 oscClk = ~oscClk;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Each level held 3+ cycles so the synchroniser never misses an edge
    task automatic count_pulse();
        @(posedge clk_sys);
        cntPin <= 1'b0;
        repeat (3) @(posedge clk_sys);
        cntPin <= 1'b1;
        repeat (4) @(posedge clk_sys);
    endtask
    // Level stands long enough for the 3-flop path to act
    task automatic trig_set(input logic l);
        @(posedge clk_sys);
        trigPin <= l;
        repeat (5) @(posedge clk_sys);
    endtask
endmodule // utc_pin_model

// ---- updown_timer_capture_reload_tb_top.sv ----
// Self-checking testbench for the up/down timer with capture and reload
`timescale 1ns/1ns
module updown_timer_capture_reload_tb_top;
    import utc_pkg::*;
    logic        clk_sys = 1'b0;
    logic        srst    = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic        ce      = 1'b1;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, irq, trigPin, cntPin, oscClk;
    int          n_mismatch, comparisons, seed, cnt, rc, wf, ef, ctl, cfg, msk;
    int          trg = 1;

    utc_timer dut (.clk_sys(clk_sys), .srst(srst), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .extTrigPin(trigPin),
        .extCountPin(cntPin), .extOscClk(oscClk), .irq(irq));
    utc_pin_model pm (.clk_sys(clk_sys), .cntPin(cntPin), .trigPin(trigPin),
        .oscClk(oscClk));

    // 100 ns system clock
    initial begin
        forever #50 clk_sys = ~clk_sys;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Fixed-seed xorshift keeps runs repeatable
    function automatic int xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] ex, logic [31:0] got);
        comparisons++;
        if (got !== ex) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, ex, got);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // APB master: request held until pready is seen high
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int k;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1) begin
            n_mismatch++;
            tally_and_finish();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Model register image as software should read it
    function automatic logic [31:0] mexp(logic [7:0] a);
        case (a)
            OFS_CTRL:   return {24'h0, wf[0], ef[0], 2'b00, ctl[3:0]};
            OFS_CFG:    return cfg;
            OFS_CNT_LO: return cnt & 32'hff;
            OFS_CNT_HI: return cnt >> 8;
            OFS_RC_LO:  return rc & 32'hff;
            OFS_RC_HI:  return rc >> 8;
            OFS_STAT:   return {ef[0], wf[0]};
            OFS_MASK:   return msk;
            default:    return 32'h0;
        endcase
    endfunction
    task automatic rd(logic [7:0] a);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk($sformatf("reg %h", a), mexp(a), r);
        chk("pslverr", 0, e);
    endtask
    // Writes update the model alongside the design
    task automatic wr(logic [7:0] a, logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, {24'h0, d}, r, e);
        case (a)
            OFS_CTRL: begin
                wf &= d[7];
                ef &= d[6];
                ctl = d[3:0];
            end
            OFS_CFG:    cfg = d & 8'h19;
            OFS_CNT_LO: cnt = (cnt & 16'hff00) | d;
            OFS_CNT_HI: cnt = (cnt & 16'h00ff) | (d << 8);
            OFS_RC_LO:  rc = (rc & 16'hff00) | d;
            OFS_RC_HI:  rc = (rc & 16'h00ff) | (d << 8);
            OFS_STAT: begin
                wf &= ~d[0];
                ef &= ~d[1];
            end
            OFS_MASK:   msk = d[1:0];
            default: ;
        endcase
    endtask
    task automatic w16(logic [7:0] a, logic [15:0] v);
        wr(a, v[7:0]);
        wr(a + 8'h04, v[15:8]);
    endtask
    task automatic chkall();
        for (int a = 0; a < 32; a += 4)
            rd(a[7:0]);
        chk("irq", (wf & msk[0]) | (ef & msk[1] & ctl[0]), irq);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // n count-pin events; wrap handling differs between capture and reload
    task automatic pulse(int n);
        int w;
        int dn;
        repeat (n) begin
            pm.count_pulse();
            dn = cfg[0] && !trg;
            w = dn ? (cnt == (ctl[0] ? 0 : rc)) : (cnt == 16'hffff);
            if (!ctl[2] || !ctl[1])
                continue;
            cnt = w ? (dn ? 16'hffff : (ctl[0] ? 0 : rc)) : (dn ? cnt - 1 : cnt + 1);
            cnt &= 16'hffff;
            wf |= w;
            if (w && !ctl[0])
                ef ^= 1;
        end
    endtask
    task automatic trig(int l);
        if (trg && !l && ctl[3] && !cfg[0]) begin
            if (ctl[0])
                rc = cnt;
            else
                cnt = rc;
            ef = 1;
        end
        trg = l;
        pm.trig_set(l[0]);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [31:0] r;
        logic        e;
        int          v;
        int          lo[4] = '{218, 118, 18, 7};
        int          hi[4] = '{226, 124, 22, 11};
        seed = 27;
        repeat (10) @(posedge clk_sys);
        srst <= 1'b0;
        chkall();
        apb(1'b1, 8'h20, 32'hff, r, e);
        chk("pslverr", 1, e);
        apb(1'b0, 8'h20, 32'h0, r, e);
        chk("pslverr", 1, e);
        chk("unmapped", 0, r);
        v = xs();
        w16(OFS_CNT_LO, v[15:0]);
        w16(OFS_RC_LO, v[31:16]);
        chkall();
        wr(OFS_MASK, 8'h03);
        w16(OFS_CNT_LO, 16'hfffe);
        wr(OFS_CTRL, 8'hc6);
        pulse(3);
        chkall();
        wr(OFS_CTRL, 8'hc2);
        pulse(2);
        chkall();
        wr(OFS_STAT, 8'h01);
        chkall();
        wr(OFS_CTRL, 8'h80);
        chkall();
        v = xs();
        w16(OFS_CNT_LO, v[15:0]);
        trig(0);
        trig(1);
        chkall();
        wr(OFS_CTRL, 8'hc8);
        trig(0);
        trig(1);
        chkall();
        w16(OFS_CNT_LO, 16'hffff);
        wr(OFS_CTRL, 8'hc7);
        pulse(2);
        trig(0);
        trig(1);
        chkall();
        wr(OFS_CTRL, 8'hcf);
        pulse(1);
        trig(0);
        trig(1);
        chkall();
        wr(OFS_STAT, 8'h01);
        wr(OFS_MASK, 8'h02);
        chkall();
        wr(OFS_MASK, 8'h01);
        chkall();
        wr(OFS_CFG, 8'h01);
        w16(OFS_CNT_LO, 16'h0001);
        trig(0);
        pulse(2);
        chkall();
        trig(1);
        pulse(1);
        chkall();
        w16(OFS_RC_LO, {1'b0, v[30:16]});
        w16(OFS_CNT_LO, {1'b0, v[30:16]} + 16'h2);
        wr(OFS_CTRL, 8'hce);
        trig(0);
        pulse(3);
        chkall();
        // Clock source rates, oscillator included; prescaler phase gives a small window
        for (int s = 0; s < 4; s++) begin
            w16(OFS_CNT_LO, 16'h0000);
            wr(OFS_CFG, 8'(s << 3));
            wr(OFS_CTRL, 8'h84);
            if (s == 0) begin
                // Clock enable low for 20 edges: the count must lose 17 to 25 ticks to land in the window
                repeat (100) @(posedge clk_sys);
                ce <= 1'b0;
                repeat (20) @(posedge clk_sys);
                ce <= 1'b1;
                repeat (120) @(posedge clk_sys);
            end else begin
                repeat (240) @(posedge clk_sys);
            end
            wr(OFS_CTRL, 8'h80);
            apb(1'b0, OFS_CNT_LO, 32'h0, r, e);
            chk($sformatf("rate %0d", s), 1, r >= lo[s] && r <= hi[s]);
        end
        tally_and_finish();
    end
endmodule // updown_timer_capture_reload_tb_top
